// file: rtl/event_register_bank.sv
`timescale 1ns/1ns
`include "event_regs_consts.svh"

// Operation
// - Shutdown returns every register to reset.
// - Event source resets zero; reads clear it.
// - Bit 6 set when negative rail not good.
// - Bit 5 set when positive rail good.
// - Bit 4 set on negative rail short.
// - Bit 3 set on positive rail short.
// - Bit 2 latches negative overload until read.
// - Bit 1 latches positive overload until read.
// - Bit 0 set on external fault input.
// - Mask bits suppress the interrupt from sources, default one.
module event_register_bank
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic shutdown,
    input wire logic neg_rail_below_pgood,
    input wire logic pos_rail_above_pgood,
    input wire logic neg_rail_short,
    input wire logic pos_rail_short,
    input wire logic neg_rail_overload,
    input wire logic pos_rail_overload,
    input wire logic external_fault_input,
    input wire logic [2:0] lockout_events,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire event_regs_pkg::reg_byte_t reg_addr,
    input wire event_regs_pkg::reg_byte_t reg_wdata,
    output event_regs_pkg::reg_byte_t reg_rdata,
    output logic irq_pending,
    output event_regs_pkg::reg_byte_t global_control,
    output event_regs_pkg::reg_byte_t converter_config_a,
    output event_regs_pkg::reg_byte_t converter_config_b,
    output event_regs_pkg::reg_byte_t negative_level_low,
    output event_regs_pkg::reg_byte_t negative_rail_delays,
    output event_regs_pkg::reg_byte_t positive_rail_delays
);
    import event_regs_pkg::*;

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    event_vec_t live_cond;
    event_vec_t event_flags;
    logic src_read;

    always_comb
    begin
        live_cond = '0;
        live_cond[`BIT_NEG_PGOOD] = neg_rail_below_pgood;
        live_cond[`BIT_POS_PGOOD] = pos_rail_above_pgood;
        live_cond[`BIT_NEG_SHORT] = neg_rail_short;
        live_cond[`BIT_POS_SHORT] = pos_rail_short;
        live_cond[`BIT_NEG_OVLD] = neg_rail_overload;
        live_cond[`BIT_POS_OVLD] = pos_rail_overload;
        live_cond[`BIT_EXT_FAULT] = external_fault_input;
    end

    assign src_read = reg_rd && (reg_addr == `ADDR_EVENT_SOURCE);

    event_latch u_event_latch
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .shutdown(shutdown),
        .set_in(live_cond),
        .clear_all(src_read),
        .flags(event_flags)
    );

    // ------------------------------------------------------------
    // Writable and lockout registers
    // ------------------------------------------------------------
    reg_byte_t mask_r, mask_nxt;
    reg_byte_t glob_r, glob_nxt;
    reg_byte_t cfga_r, cfga_nxt;
    reg_byte_t cfgb_r, cfgb_nxt;
    reg_byte_t lvl_r, lvl_nxt;
    reg_byte_t dneg_r, dneg_nxt;
    reg_byte_t dpos_r, dpos_nxt;
    reg_byte_t lock_r, lock_nxt;
    logic lock_read;

    assign lock_read = reg_rd && (reg_addr == `ADDR_LOCKOUT_FLAGS);

    always_comb
    begin
        mask_nxt = mask_r;
        glob_nxt = glob_r;
        cfga_nxt = cfga_r;
        cfgb_nxt = cfgb_r;
        lvl_nxt = lvl_r;
        dneg_nxt = dneg_r;
        dpos_nxt = dpos_r;
        lock_nxt = lock_r;
        if (lock_read)
            lock_nxt = '0;
        lock_nxt = lock_nxt | ({4'h0, lockout_events, 1'b0} & `LOCKOUT_BITS_MASK);
        if (reg_wr)
        begin
            case (reg_addr)
                `ADDR_EVENT_MASK: mask_nxt = reg_wdata & `EVENT_BITS_MASK;
                `ADDR_GLOBAL_CONTROL: glob_nxt = reg_wdata & `GLOBAL_CTRL_MASK;
                `ADDR_CONV_CFG_A: cfga_nxt = reg_wdata & `CONV_CFG_A_MASK;
                `ADDR_CONV_CFG_B: cfgb_nxt = reg_wdata & `CONV_CFG_B_MASK;
                `ADDR_NEG_LEVEL_LOW: lvl_nxt = reg_wdata;
                `ADDR_NEG_DELAYS: dneg_nxt = reg_wdata;
                `ADDR_POS_DELAYS: dpos_nxt = reg_wdata;
                default: ;
            endcase
        end
        if (shutdown)
        begin
            mask_nxt = `EVENT_MASK_RESET;
            glob_nxt = `CFG_RESET;
            cfga_nxt = `CFG_RESET;
            cfgb_nxt = `CFG_RESET;
            lvl_nxt = `CFG_RESET;
            dneg_nxt = `CFG_RESET;
            dpos_nxt = `CFG_RESET;
            lock_nxt = `CFG_RESET;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            mask_r <= `EVENT_MASK_RESET;
            glob_r <= `CFG_RESET;
            cfga_r <= `CFG_RESET;
            cfgb_r <= `CFG_RESET;
            lvl_r <= `CFG_RESET;
            dneg_r <= `CFG_RESET;
            dpos_r <= `CFG_RESET;
            lock_r <= `CFG_RESET;
        end
        else if (clk_en)
        begin
            mask_r <= mask_nxt;
            glob_r <= glob_nxt;
            cfga_r <= cfga_nxt;
            cfgb_r <= cfgb_nxt;
            lvl_r <= lvl_nxt;
            dneg_r <= dneg_nxt;
            dpos_r <= dpos_nxt;
            lock_r <= lock_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data and interrupt
    // ------------------------------------------------------------
    reg_byte_t rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;

    always_comb
    begin
        case (reg_addr)
            `ADDR_EVENT_SOURCE: rdata_nxt = {1'b0, event_flags};
            `ADDR_EVENT_MASK: rdata_nxt = mask_r;
            `ADDR_LIVE_CONDITION: rdata_nxt = {1'b0, live_cond};
            `ADDR_LOCKOUT_FLAGS: rdata_nxt = lock_r;
            `ADDR_GLOBAL_CONTROL: rdata_nxt = glob_r;
            `ADDR_CONV_CFG_A: rdata_nxt = cfga_r;
            `ADDR_CONV_CFG_B: rdata_nxt = cfgb_r;
            `ADDR_NEG_LEVEL_LOW: rdata_nxt = lvl_r;
            `ADDR_NEG_DELAYS: rdata_nxt = dneg_r;
            `ADDR_POS_DELAYS: rdata_nxt = dpos_r;
            default: rdata_nxt = 8'h00;
        endcase
        if (!reg_rd)
            rdata_nxt = rdata_r;
        irq_nxt = |(event_flags & ~mask_r[6:0]);
        if (shutdown)
        begin
            rdata_nxt = 8'h00;
            irq_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end
        else if (clk_en)
        begin
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq_pending = irq_r;
    assign global_control = glob_r;
    assign converter_config_a = cfga_r;
    assign converter_config_b = cfgb_r;
    assign negative_level_low = lvl_r;
    assign negative_rail_delays = dneg_r;
    assign positive_rail_delays = dpos_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_shutdown_clears;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && shutdown) |=> (mask_r == `EVENT_MASK_RESET) && (event_flags == '0);
    endproperty
    a_shutdown_clears: assert property (p_shutdown_clears) else $error("shutdown left state");

    property p_read_clears;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && src_read && live_cond == '0 && !shutdown) |=> (event_flags == '0);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_neg_pgood;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && neg_rail_below_pgood && !shutdown) |=> event_flags[`BIT_NEG_PGOOD];
    endproperty
    a_neg_pgood: assert property (p_neg_pgood) else $error("neg pgood not set");

    property p_pos_pgood;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && pos_rail_above_pgood && !shutdown) |=> event_flags[`BIT_POS_PGOOD];
    endproperty
    a_pos_pgood: assert property (p_pos_pgood) else $error("pos pgood not set");

    property p_neg_short;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && neg_rail_short && !shutdown) |=> event_flags[`BIT_NEG_SHORT];
    endproperty
    a_neg_short: assert property (p_neg_short) else $error("neg short not set");

    property p_pos_short;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && pos_rail_short && !shutdown) |=> event_flags[`BIT_POS_SHORT];
    endproperty
    a_pos_short: assert property (p_pos_short) else $error("pos short not set");

    property p_neg_ovld_hold;
        @(posedge core_clk) disable iff (!resetn)
        (event_flags[`BIT_NEG_OVLD] && !src_read && !shutdown && clk_en)
            |=> event_flags[`BIT_NEG_OVLD];
    endproperty
    a_neg_ovld_hold: assert property (p_neg_ovld_hold) else $error("neg overload lost");

    property p_pos_ovld;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && pos_rail_overload && !shutdown) |=> event_flags[`BIT_POS_OVLD];
    endproperty
    a_pos_ovld: assert property (p_pos_ovld) else $error("pos overload not set");

    property p_ext_fault;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && external_fault_input && !shutdown) |=> event_flags[`BIT_EXT_FAULT];
    endproperty
    a_ext_fault: assert property (p_ext_fault) else $error("fault not set");

    property p_mask_gates;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && !shutdown && (event_flags & ~mask_r[6:0]) == '0) |=> !irq_pending;
    endproperty
    a_mask_gates: assert property (p_mask_gates) else $error("masked irq raised");

    property p_rsvd_zero;
        @(posedge core_clk) disable iff (!resetn)
        $rose(reg_rd) ##0 (clk_en && reg_addr == `ADDR_EVENT_SOURCE) |=> (reg_rdata[7] == 1'b0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
endmodule

// file: pkg/event_regs_consts.svh
`ifndef EVENT_REGS_CONSTS_SVH
`define EVENT_REGS_CONSTS_SVH

// Register addresses.
`define ADDR_EVENT_SOURCE 8'h01
`define ADDR_EVENT_MASK 8'h02
`define ADDR_LIVE_CONDITION 8'h03
`define ADDR_LOCKOUT_FLAGS 8'h04
`define ADDR_GLOBAL_CONTROL 8'h05
`define ADDR_CONV_CFG_A 8'h30
`define ADDR_CONV_CFG_B 8'h31
`define ADDR_NEG_LEVEL_LOW 8'h32
`define ADDR_NEG_DELAYS 8'h40
`define ADDR_POS_DELAYS 8'h41

// Event bit positions.
`define BIT_NEG_PGOOD 6
`define BIT_POS_PGOOD 5
`define BIT_NEG_SHORT 4
`define BIT_POS_SHORT 3
`define BIT_NEG_OVLD 2
`define BIT_POS_OVLD 1
`define BIT_EXT_FAULT 0

// Register bit masks and reset values.
`define EVENT_BITS_MASK 8'h7f
`define LOCKOUT_BITS_MASK 8'h0e
`define GLOBAL_CTRL_MASK 8'h0f
`define CONV_CFG_A_MASK 8'h77
`define CONV_CFG_B_MASK 8'h01
`define EVENT_SOURCE_RESET 8'h00
`define EVENT_MASK_RESET 8'h7f
`define CFG_RESET 8'h00

`endif

// file: pkg/event_regs_pkg.sv
package event_regs_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [6:0] event_vec_t;
endpackage

// file: rtl/event_latch.sv
`timescale 1ns/1ns
`include "event_regs_consts.svh"

module event_latch
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic shutdown,
    input wire event_regs_pkg::event_vec_t set_in,
    input wire logic clear_all,
    output event_regs_pkg::event_vec_t flags
);
    import event_regs_pkg::*;

    event_vec_t flags_r;
    event_vec_t flags_nxt;

    // Each flag sets on its cause; a cause in the clearing cycle is kept.
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1)
        begin : g_flag
            always_comb
            begin
                if (shutdown)
                    flags_nxt[gi] = 1'b0;
                else if (set_in[gi])
                    flags_nxt[gi] = 1'b1;
                else if (clear_all)
                    flags_nxt[gi] = 1'b0;
                else
                    flags_nxt[gi] = flags_r[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            flags_r <= event_vec_t'(`EVENT_SOURCE_RESET);
        else if (clk_en)
            flags_r <= flags_nxt;
    end

    assign flags = flags_r;
endmodule

// file: verif/host_model.sv
`timescale 1ns/1ns

module host_model
(
    input wire logic core_clk,
    input wire event_regs_pkg::reg_byte_t reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output event_regs_pkg::reg_byte_t reg_addr,
    output event_regs_pkg::reg_byte_t reg_wdata
);
    import event_regs_pkg::*;

    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // Between accesses the bus shows the inverted address, and after a write also inverted data, so nothing stale looks valid.
    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        @(posedge core_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input reg_byte_t a, output reg_byte_t d);
        @(posedge core_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

// file: verif/tb_event_register_bank.sv
`timescale 1ns/1ns

`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("ERROR %s expected %h seen %h", nm, e, g); \
        end \
    end

module tb_event_register_bank;
    import event_regs_pkg::*;

    logic core_clk;
    logic resetn;
    logic clk_en;
    logic shutdown;
    logic [6:0] cause;
    logic [2:0] lock;
    logic reg_wr;
    logic reg_rd;
    reg_byte_t reg_addr;
    reg_byte_t reg_wdata;
    reg_byte_t reg_rdata;
    logic irq_pending;
    reg_byte_t cfg_out[6];
    reg_byte_t d;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    event_register_bank u_dut
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .shutdown(shutdown),
        .neg_rail_below_pgood(cause[6]),
        .pos_rail_above_pgood(cause[5]),
        .neg_rail_short(cause[4]),
        .pos_rail_short(cause[3]),
        .neg_rail_overload(cause[2]),
        .pos_rail_overload(cause[1]),
        .external_fault_input(cause[0]),
        .lockout_events(lock),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .irq_pending(irq_pending),
        .global_control(cfg_out[0]),
        .converter_config_a(cfg_out[1]),
        .converter_config_b(cfg_out[2]),
        .negative_level_low(cfg_out[3]),
        .negative_rail_delays(cfg_out[4]),
        .positive_rail_delays(cfg_out[5])
    );

    host_model u_host
    (
        .core_clk(core_clk),
        .reg_rdata(reg_rdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic pulse(input logic [6:0] c, input logic [2:0] l, input logic sd);
        @(posedge core_clk);
        #1;
        cause = c;
        lock = l;
        shutdown = sd;
        @(posedge core_clk);
        #1;
        cause = 7'h00;
        lock = 3'h0;
        shutdown = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        u_host.rd(8'h01, d);
        `CHK("source", 8'h00, d)
        u_host.rd(8'h02, d);
        `CHK("mask", 8'h7f, d)
        u_host.rd(8'h10, d);
        `CHK("unmapped", 8'h00, d)
        `CHK("irq", 1'b0, irq_pending)
    endtask

    task automatic t_freeze();
        @(posedge core_clk);
        #1;
        clk_en = 1'b0;
        u_host.wr(8'h02, 8'h00);
        pulse(7'h7f, 3'h7, 1'b0);
        clk_en = 1'b1;
        u_host.rd(8'h02, d);
        `CHK("frozen mask", 8'h7f, d)
        u_host.rd(8'h01, d);
        `CHK("frozen source", 8'h00, d)
        u_host.rd(8'h04, d);
        `CHK("frozen lockout", 8'h00, d)
        u_host.wr(8'h02, 8'h00);
        pulse(7'h01, 3'h0, 1'b0);
        @(posedge core_clk);
        #1;
        `CHK("pre reset irq", 1'b1, irq_pending)
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        u_host.rd(8'h02, d);
        `CHK("reset mask", 8'h7f, d)
        u_host.rd(8'h01, d);
        `CHK("reset source", 8'h00, d)
        `CHK("reset irq", 1'b0, irq_pending)
    endtask

    task automatic t_live();
        @(posedge core_clk);
        #1;
        cause = 7'h7f;
        u_host.rd(8'h03, d);
        `CHK("live", 8'h7f, d)
        u_host.rd(8'h01, d);
        `CHK("source held", 8'h7f, d)
        cause = 7'h00;
        u_host.rd(8'h01, d);
        `CHK("source kept", 8'h7f, d)
        u_host.rd(8'h01, d);
        `CHK("source clear", 8'h00, d)
    endtask

    task automatic t_events();
        for (int i = 0; i < 7; i++)
        begin
            pulse(7'h01 << i, 3'h0, 1'b0);
            u_host.rd(8'h01, d);
            `CHK("event", {1'b0, 7'h01 << i}, d)
            u_host.rd(8'h01, d);
            `CHK("cleared", 8'h00, d)
        end
    endtask

    task automatic t_mask();
        u_host.wr(8'h02, 8'hff);
        u_host.rd(8'h02, d);
        `CHK("mask rsvd", 8'h7f, d)
        pulse(7'h7f, 3'h0, 1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("irq masked", 1'b0, irq_pending)
        u_host.wr(8'h02, 8'h7b);
        u_host.rd(8'h01, d);
        `CHK("all events", 8'h7f, d)
        pulse(7'h04, 3'h0, 1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("irq unmasked", 1'b1, irq_pending)
        u_host.rd(8'h01, d);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("irq after read", 1'b0, irq_pending)
    endtask

    task automatic t_config();
        reg_byte_t a[6] = '{8'h05, 8'h30, 8'h31, 8'h32, 8'h40, 8'h41};
        reg_byte_t m[6] = '{8'h0f, 8'h77, 8'h01, 8'hff, 8'hff, 8'hff};
        for (int i = 0; i < 6; i++)
        begin
            u_host.wr(a[i], 8'hff);
            u_host.rd(a[i], d);
            `CHK("cfg read", m[i], d)
            `CHK("cfg port", m[i], cfg_out[i])
        end
        u_host.wr(8'h04, 8'hff);
        u_host.rd(8'h04, d);
        `CHK("lockout ro", 8'h00, d)
        pulse(7'h00, 3'h7, 1'b0);
        u_host.rd(8'h04, d);
        `CHK("lockout", 8'h0e, d)
    endtask

    task automatic t_shutdown();
        u_host.wr(8'h02, 8'h00);
        pulse(7'h01, 3'h7, 1'b0);
        pulse(7'h00, 3'h0, 1'b1);
        `CHK("sd irq", 1'b0, irq_pending)
        u_host.rd(8'h04, d);
        `CHK("sd lockout", 8'h00, d)
        u_host.rd(8'h01, d);
        `CHK("sd source", 8'h00, d)
        u_host.rd(8'h02, d);
        `CHK("sd mask", 8'h7f, d)
        for (int i = 0; i < 6; i++)
            `CHK("sd cfg", 8'h00, cfg_out[i])
    endtask

    initial
    begin
        resetn = 1'b0;
        clk_en = 1'b1;
        shutdown = 1'b0;
        cause = 7'h00;
        lock = 3'h0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        t_reset();
        t_freeze();
        t_events();
        t_live();
        t_mask();
        t_config();
        t_shutdown();
        test_done();
    end
endmodule
